// File: hw/bcc_top.sv
/*
  Single-button user interface of a two-channel receiver: phase selection,
  channel behaviour configuration, activation time entry, memory wipe,
  fault indication and LED output display, plus the two output drivers.
  Assumes a code decoder on the same clock that pulses FRAME_VALID and
  CODE_HIT1/2 per decoded frame, and a code memory that answers wipes.
*/
`include "bcc_params.svh"
module bcc_top #(
  parameter int TICK_CYCLES    = `BCC_TICK_CYCLES,
  parameter int HOLD_MS        = `BCC_HOLD_MS,
  parameter int IDLE_MS        = `BCC_IDLE_MS,
  parameter int ENTRY_MS       = `BCC_ENTRY_MS,
  parameter int ACK_MS         = `BCC_ACK_MS,
  parameter int BLANK_MS       = `BCC_BLANK_MS,
  parameter int FAST_HALF_MS   = `BCC_FAST_HALF_MS,
  parameter int SLOW_HALF_MS   = `BCC_SLOW_HALF_MS,
  parameter int FRAME_HOLD_MS  = `BCC_FRAME_HOLD_MS,
  parameter int STEP_MS        = `BCC_STEP_S * 1000,
  parameter int DEBOUNCE_MS    = `BCC_DEBOUNCE_MS,
  parameter int CODE_CAPACITY  = `BCC_CODE_CAPACITY
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic BUTTON_N,
  input  wire logic FRAME_VALID,
  input  wire logic FRAME_KNOWN,
  input  wire logic CODE_HIT1,
  input  wire logic CODE_HIT2,
  input  wire logic MEM_FAULT,
  input  wire logic WIPE_DONE,
  output logic      OUT1,
  output logic      OUT2,
  output logic      LED_GREEN,
  output logic      LED_RED,
  output logic      LEARN_STB,
  output logic      LEARN_CH2,
  output logic      FORGET_STB,
  output logic      WIPE_STB,
  output logic      MEM_FULL
);

  ////////////////////////////////////////////////////////////////////////////
  // Common tick and button

  logic [17:0] div_ff;
  logic        tick_ff;
  logic        btn_w;
  logic        press_w;

  // One ms tick shared by every timeout
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_ff  <= 18'h00000;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= (div_ff == 18'(TICK_CYCLES - 1)) ? 18'h00000 : div_ff + 18'h00001;
      tick_ff <= (div_ff == 18'(TICK_CYCLES - 1));
    end
  end

  bcc_debounce #(
    .DEBOUNCE_MS (DEBOUNCE_MS)
  ) u_button (
    .clk         (CLK),
    .rst_n       (RST_N),
    .tick        (tick_ff),
    .pin_n       (BUTTON_N),
    .pressed     (btn_w),
    .press_pulse (press_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and timers

  bcc_pkg::bcc_state_type state_ff;
  bcc_pkg::bcc_state_type nxt_state;
  logic [15:0] tmr_ff;
  logic [15:0] hold_ff;
  logic [7:0]  sub_ff;
  logic [2:0]  slot_ff;
  logic        chan_ff;
  logic        nxt_chan;
  logic [7:0]  presses_ff;
  logic [7:0]  nxt_presses;
  logic [7:0]  show_cnt_ff;
  logic [7:0]  nxt_show_cnt;
  logic        show_on_ff;
  logic        nxt_show_on;
  logic        show_orange_ff;
  logic        nxt_show_orange;
  logic        blank_ff;
  logic        tmr_clr;
  logic        cmt_en;
  bcc_pkg::bcc_mode_type cmt_mode;
  logic [7:0]  cmt_units;
  logic        learn_go;
  logic        forget_go;
  logic        wipe_go;
  logic        wipe_fin;
  logic [8:0]  stored_ff;
  bcc_pkg::bcc_mode_type mode_ff [2];
  logic [7:0]  units_ff [2];

  // Timer conditions, all on the common ms tick, plus the code memory room check
  logic hold_done_w;
  logic idle_w;
  logic entry_idle_w;
  logic half_end_w;
  logic fast_step_w;
  logic room_w;
  assign hold_done_w  = (hold_ff >= 16'(HOLD_MS)) && btn_w;
  assign idle_w       = (tmr_ff >= 16'(IDLE_MS));
  assign entry_idle_w = (tmr_ff >= 16'(ENTRY_MS));
  assign half_end_w   = tick_ff && (tmr_ff >= 16'(SLOW_HALF_MS - 1));
  assign fast_step_w  = tick_ff && (sub_ff == 8'(FAST_HALF_MS - 1));
  assign room_w       = (stored_ff < 9'(CODE_CAPACITY)) || FRAME_KNOWN;

  // Phase and configuration sequencing
  always_comb begin
    nxt_state       = state_ff;
    nxt_chan        = chan_ff;
    nxt_presses     = presses_ff;
    nxt_show_cnt    = show_cnt_ff;
    nxt_show_on     = show_on_ff;
    nxt_show_orange = show_orange_ff;
    tmr_clr         = 1'b0;
    cmt_en          = 1'b0;
    cmt_mode        = bcc_pkg::MODE_MONO;
    cmt_units       = presses_ff;
    learn_go        = 1'b0;
    forget_go       = 1'b0;
    wipe_go         = 1'b0;
    wipe_fin        = 1'b0;
    if (MEM_FAULT) begin
      nxt_state = bcc_pkg::ST_MEMERR;
    end else begin
      case (state_ff)
        bcc_pkg::ST_NORMAL: begin
          if (press_w) begin
            nxt_state = bcc_pkg::ST_LEARN1;
            nxt_chan  = 1'b0;
          end
        end
        bcc_pkg::ST_LEARN1, bcc_pkg::ST_LEARN2: begin
          if (hold_done_w) begin
            nxt_state = bcc_pkg::ST_CFG_MONO;
          end else if (press_w) begin
            nxt_state = (state_ff == bcc_pkg::ST_LEARN1) ? bcc_pkg::ST_LEARN2
                                                         : bcc_pkg::ST_ERASE1;
            nxt_chan  = 1'b1;
          end else if (FRAME_VALID && room_w) begin
            learn_go = 1'b1;
            tmr_clr  = 1'b1;
          end else if (idle_w) begin
            nxt_state = bcc_pkg::ST_NORMAL;
          end
        end
        bcc_pkg::ST_ERASE1: begin
          if (hold_done_w) begin
            nxt_state = bcc_pkg::ST_ERASE_ALL;
          end else if (press_w) begin
            nxt_state = bcc_pkg::ST_NORMAL;
          end else if (FRAME_VALID && FRAME_KNOWN) begin
            forget_go = 1'b1;
            tmr_clr   = 1'b1;
          end else if (idle_w) begin
            nxt_state = bcc_pkg::ST_NORMAL;
          end
        end
        bcc_pkg::ST_CFG_MONO: begin
          if (press_w) begin
            nxt_state = bcc_pkg::ST_CFG_BI;
          end else if (idle_w) begin
            cmt_en          = 1'b1;
            nxt_state       = bcc_pkg::ST_SHOW;
            nxt_show_cnt    = 8'h01;
            nxt_show_on     = 1'b1;
            nxt_show_orange = 1'b0;
          end
        end
        bcc_pkg::ST_CFG_BI: begin
          if (press_w) begin
            nxt_state = bcc_pkg::ST_CFG_TIM;
          end else if (idle_w) begin
            cmt_en          = 1'b1;
            cmt_mode        = bcc_pkg::MODE_BI;
            nxt_state       = bcc_pkg::ST_SHOW;
            nxt_show_cnt    = 8'h02;
            nxt_show_on     = 1'b1;
            nxt_show_orange = 1'b0;
          end
        end
        bcc_pkg::ST_CFG_TIM: begin
          if (press_w) begin
            nxt_state = bcc_pkg::ST_NORMAL;
          end else if (idle_w) begin
            nxt_state = bcc_pkg::ST_TIME_WAIT;
          end
        end
        bcc_pkg::ST_TIME_WAIT: begin
          if (press_w) begin
            nxt_state   = bcc_pkg::ST_TIME_ENT;
            nxt_presses = 8'h01;
          end else if (entry_idle_w) begin
            cmt_en    = 1'b1;
            cmt_mode  = bcc_pkg::MODE_TIMED;
            cmt_units = 8'(`BCC_DEFAULT_UNITS);
            nxt_state = bcc_pkg::ST_NORMAL;
          end
        end
        bcc_pkg::ST_TIME_ENT: begin
          if (press_w) begin
            if (presses_ff < 8'(`BCC_MAX_PRESSES)) begin
              nxt_presses = presses_ff + 8'h01;
            end
          end else if (entry_idle_w) begin
            cmt_en          = 1'b1;
            cmt_mode        = bcc_pkg::MODE_TIMED;
            nxt_state       = bcc_pkg::ST_SHOW;
            nxt_show_cnt    = presses_ff;
            nxt_show_on     = 1'b0;
            nxt_show_orange = 1'b1;
          end
        end
        bcc_pkg::ST_SHOW: begin
          if (half_end_w) begin
            tmr_clr     = 1'b1;
            nxt_show_on = ~show_on_ff;
            if (show_on_ff) begin
              nxt_show_cnt = show_cnt_ff - 8'h01;
              if (show_cnt_ff <= 8'h01) begin
                nxt_state = bcc_pkg::ST_NORMAL;
              end
            end
          end
        end
        bcc_pkg::ST_ERASE_ALL: begin
          if (!btn_w) begin
            nxt_state = bcc_pkg::ST_WIPE;
            wipe_go   = 1'b1;
          end
        end
        bcc_pkg::ST_WIPE: begin
          if (WIPE_DONE) begin
            wipe_fin  = 1'b1;
            nxt_state = bcc_pkg::ST_NORMAL;
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  // Any state change or press restarts the idle window
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= bcc_pkg::ST_NORMAL;
      tmr_ff   <= 16'h0000;
      hold_ff  <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      tmr_ff   <= (tmr_clr || press_w || nxt_state != state_ff) ? 16'h0000 :
                  ((tick_ff && tmr_ff != 16'hffff) ? tmr_ff + 16'h0001 : tmr_ff);
      hold_ff  <= (!btn_w || press_w) ? 16'h0000 :
                  ((tick_ff && hold_ff != 16'hffff) ? hold_ff + 16'h0001 : hold_ff);
    end
  end

  // Sequence registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      chan_ff        <= 1'b0;
      presses_ff     <= 8'h00;
      show_cnt_ff    <= 8'h00;
      show_on_ff     <= 1'b0;
      show_orange_ff <= 1'b0;
    end else begin
      chan_ff        <= nxt_chan;
      presses_ff     <= nxt_presses;
      show_cnt_ff    <= nxt_show_cnt;
      show_on_ff     <= nxt_show_on;
      show_orange_ff <= nxt_show_orange;
    end
  end

  // Stored behaviour per channel; a wipe returns both to monostable
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_ff[0]  <= bcc_pkg::MODE_MONO;
      mode_ff[1]  <= bcc_pkg::MODE_MONO;
      units_ff[0] <= 8'(`BCC_DEFAULT_UNITS);
      units_ff[1] <= 8'(`BCC_DEFAULT_UNITS);
    end else if (wipe_fin) begin
      mode_ff[0]  <= bcc_pkg::MODE_MONO;
      mode_ff[1]  <= bcc_pkg::MODE_MONO;
    end else if (cmt_en) begin
      mode_ff[chan_ff]  <= cmt_mode;
      units_ff[chan_ff] <= cmt_units;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code memory requests and occupancy

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stored_ff  <= 9'h000;
      LEARN_STB  <= 1'b0;
      LEARN_CH2  <= 1'b0;
      FORGET_STB <= 1'b0;
      WIPE_STB   <= 1'b0;
      MEM_FULL   <= 1'b0;
      blank_ff   <= 1'b0;
    end else begin
      LEARN_STB  <= learn_go;
      LEARN_CH2  <= learn_go ? chan_ff : LEARN_CH2;
      FORGET_STB <= forget_go;
      WIPE_STB   <= wipe_go;
      MEM_FULL   <= (stored_ff >= 9'(CODE_CAPACITY));
      if (wipe_fin) begin
        stored_ff <= 9'h000;
      end else if (learn_go && !FRAME_KNOWN) begin
        stored_ff <= stored_ff + 9'h001;
      end else if (forget_go && stored_ff != 9'h000) begin
        stored_ff <= stored_ff - 9'h001;
      end
      // LED blanked briefly to confirm a learn or forget
      blank_ff <= (learn_go || forget_go) ? 1'b1 :
                  ((tmr_ff >= 16'(BLANK_MS) || nxt_state != state_ff) ? 1'b0 : blank_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers per channel

  logic [1:0] hit_w;
  logic [1:0] act_w;
  assign hit_w = {CODE_HIT2, CODE_HIT1} & {2{state_ff == bcc_pkg::ST_NORMAL}};

  for (genvar ch = 0; ch < 2; ch++) begin : g_out
    logic [20:0] run_ff;
    logic [7:0]  seen_ff;
    logic        act_ff;
    logic        fresh_w;
    assign fresh_w = hit_w[ch] && (seen_ff == 8'h00);
    // Bistable toggles only on the first frame of a burst of repeats
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        run_ff  <= 21'h000000;
        seen_ff <= 8'h00;
        act_ff  <= 1'b0;
      end else begin
        seen_ff <= hit_w[ch] ? 8'(FRAME_HOLD_MS) :
                   ((tick_ff && seen_ff != 8'h00) ? seen_ff - 8'h01 : seen_ff);
        if (hit_w[ch] && mode_ff[ch] == bcc_pkg::MODE_TIMED) begin
          run_ff <= 21'(units_ff[ch] * STEP_MS);
        end else if (hit_w[ch]) begin
          run_ff <= 21'(FRAME_HOLD_MS);
        end else if (tick_ff && run_ff != 21'h000000) begin
          run_ff <= run_ff - 21'h000001;
        end
        if (mode_ff[ch] == bcc_pkg::MODE_BI) begin
          act_ff <= fresh_w ? ~act_ff : act_ff;
        end else begin
          act_ff <= hit_w[ch] || (run_ff > 21'h000001) ||
                    (run_ff == 21'h000001 && !tick_ff);
        end
      end
    end
    assign act_w[ch] = act_ff;
  end

  assign OUT1 = act_w[0];
  assign OUT2 = act_w[1];

  ////////////////////////////////////////////////////////////////////////////
  // LED patterns

  logic [2:0] wrap_w;
  logic [2:0] burst_w;
  logic       burst_on_w;
  logic       cg_w;
  logic       cr_w;
  logic       nxt_green;
  logic       nxt_red;

  // Burst length: n fast flashes then a two-slot gap; with n of 1 the flash repeats with no gap
  assign burst_w    = (state_ff == bcc_pkg::ST_CFG_TIM) ? 3'h3 :
                      ((state_ff == bcc_pkg::ST_CFG_BI) ? 3'h2 : 3'h1);
  assign wrap_w     = (burst_w == 3'h1) ? 3'h1 : 3'((burst_w << 1) + 3'h1);
  assign burst_on_w = !slot_ff[0] && (slot_ff < 3'(burst_w << 1));
  assign cg_w       = !chan_ff;
  assign cr_w       = chan_ff;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sub_ff  <= 8'h00;
      slot_ff <= 3'h0;
    end else if (nxt_state != state_ff) begin
      sub_ff  <= 8'h00;
      slot_ff <= 3'h0;
    end else if (tick_ff) begin
      sub_ff  <= fast_step_w ? 8'h00 : sub_ff + 8'h01;
      slot_ff <= !fast_step_w ? slot_ff : ((slot_ff >= wrap_w) ? 3'h0 : slot_ff + 3'h1);
    end
  end

  // Colour per state; orange means both LEDs lit
  always_comb begin
    nxt_green = 1'b0;
    nxt_red   = 1'b0;
    case (state_ff)
      bcc_pkg::ST_NORMAL: begin
        nxt_green = act_w[0];
        nxt_red   = act_w[1];
      end
      bcc_pkg::ST_LEARN1, bcc_pkg::ST_LEARN2: begin
        nxt_green = cg_w && !blank_ff;
        nxt_red   = cr_w && !blank_ff;
      end
      bcc_pkg::ST_ERASE1, bcc_pkg::ST_MEMERR: begin
        nxt_green = !slot_ff[0] && !blank_ff;
        nxt_red   = !slot_ff[0] && !blank_ff;
      end
      bcc_pkg::ST_CFG_MONO, bcc_pkg::ST_CFG_BI, bcc_pkg::ST_CFG_TIM: begin
        nxt_green = cg_w && burst_on_w;
        nxt_red   = cr_w && burst_on_w;
      end
      bcc_pkg::ST_TIME_WAIT, bcc_pkg::ST_ERASE_ALL: begin
        nxt_green = 1'b1;
        nxt_red   = 1'b1;
      end
      bcc_pkg::ST_TIME_ENT: begin
        nxt_green = cg_w || (tmr_ff >= 16'(ACK_MS));
        nxt_red   = cr_w || (tmr_ff >= 16'(ACK_MS));
      end
      bcc_pkg::ST_SHOW: begin
        nxt_green = show_on_ff ? cg_w : show_orange_ff;
        nxt_red   = show_on_ff ? cr_w : show_orange_ff;
      end
      default: begin
        nxt_green = 1'b0;
        nxt_red   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LED_GREEN <= 1'b0;
      LED_RED   <= 1'b0;
    end else begin
      LED_GREEN <= nxt_green;
      LED_RED   <= nxt_red;
    end
  end

endmodule : bcc_top

// File: shared/bcc_params.svh
/*
  Constants of the button and channel configuration block: clock rate,
  millisecond tick, user interface times, limits and fixed patterns.
  Assumes a 200 MHz clock; all other times are counted in 1 ms ticks.
*/
// Operation
// - holding button 3 s in learning enters configuration, fast flash, monostable pending
// - monostable pending, 5 s idle commits monostable, one slow flash
// - press during monostable indication selects bistable, bursts of 2 fast flashes
// - bistable pending, 5 s idle commits bistable, two slow flashes
// - press during bistable indication selects timed, bursts of 3 fast flashes
// - timed pending, 5 s idle lights orange and opens time entry
// - no press within 3 s of orange commits timed with 60 s
// - each entry press shows channel colour for 0.5 s
// - each entry press adds 5 s to activation time
// - 3 s after last entry press commit, replay count as orange-to-colour steps
// - activation time saturates at 240 presses, 20 minutes
// - press during timed indication aborts, settings unchanged
// - holding button in erase phase gives steady orange, then release
// - completed wipe clears codes, both channels monostable, LED off
// - code memory fault flashes orange continuously
// - code memory holds up to 500 identities
// - normal LED green for output one, red for two, orange both
// - monostable follows frames, bistable toggles, timed holds for set time
// - short presses step learn one, learn two, single erase; 5 s expiry
// - green means channel one, red means channel two
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH

`define BCC_CLK_HZ         200000000
`define BCC_TICK_US        1000
`define BCC_TICK_CYCLES    (`BCC_CLK_HZ / 1000000 * `BCC_TICK_US)

`define BCC_HOLD_MS        3000
`define BCC_IDLE_MS        5000
`define BCC_ENTRY_MS       3000
`define BCC_ACK_MS         500
`define BCC_BLANK_MS       500
`define BCC_FAST_HALF_MS   100
`define BCC_SLOW_HALF_MS   500
`define BCC_FRAME_HOLD_MS  200
`define BCC_DEBOUNCE_MS    20

`define BCC_STEP_S         5
`define BCC_DEFAULT_S      60
`define BCC_DEFAULT_UNITS  (`BCC_DEFAULT_S / `BCC_STEP_S)
`define BCC_MAX_PRESSES    240
`define BCC_CODE_CAPACITY  500

`endif

// File: shared/bcc_pkg.sv
/*
  Types of the button and channel configuration block.
  Assumes nothing beyond the params header for the numbers.
*/
package bcc_pkg;

  typedef enum logic [12:0] {
    ST_NORMAL    = 13'h0001,
    ST_LEARN1    = 13'h0002,
    ST_LEARN2    = 13'h0004,
    ST_ERASE1    = 13'h0008,
    ST_CFG_MONO  = 13'h0010,
    ST_CFG_BI    = 13'h0020,
    ST_CFG_TIM   = 13'h0040,
    ST_TIME_WAIT = 13'h0080,
    ST_TIME_ENT  = 13'h0100,
    ST_SHOW      = 13'h0200,
    ST_ERASE_ALL = 13'h0400,
    ST_WIPE      = 13'h0800,
    ST_MEMERR    = 13'h1000
  } bcc_state_type;

  typedef enum logic [1:0] {
    MODE_MONO  = 2'h0,
    MODE_BI    = 2'h1,
    MODE_TIMED = 2'h2
  } bcc_mode_type;

endpackage : bcc_pkg

// File: hw/bcc_debounce.sv
/*
  Button conditioner: three-stage synchroniser and tick-based debounce.
  Assumes an active-low pin from outside the clock domain and a 1 ms tick.
*/
`include "bcc_params.svh"
module bcc_debounce #(
  parameter int DEBOUNCE_MS = `BCC_DEBOUNCE_MS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic pin_n,
  output logic      pressed,
  output logic      press_pulse
);

  logic       s1_ff;
  logic       s2_ff;
  logic       s3_ff;
  logic       stable_ff;
  logic       pulse_ff;
  logic [7:0] cnt_ff;
  logic       agree_w;
  logic       differ_w;
  logic       settle_w;

  // A level counts only once stages two and three agree
  assign agree_w  = (s2_ff == s3_ff);
  assign differ_w = agree_w && ((~s3_ff) != stable_ff);
  assign settle_w = differ_w && tick && (cnt_ff == 8'(DEBOUNCE_MS - 1));

  // Synchroniser chain, first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= pin_n;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Level must hold for the whole debounce window before it is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff    <= 8'h00;
      stable_ff <= 1'b0;
      pulse_ff  <= 1'b0;
    end else begin
      cnt_ff    <= (!differ_w || settle_w) ? 8'h00 : (tick ? cnt_ff + 8'h01 : cnt_ff);
      stable_ff <= settle_w ? ~stable_ff : stable_ff;
      pulse_ff  <= settle_w && !stable_ff;
    end
  end

  assign pressed     = stable_ff;
  assign press_pulse = pulse_ff;

endmodule : bcc_debounce

// File: verif/bcc_top_monitor.sv
/* Port assertions for bcc_top.
   Assumes the bench's shortened timing and one clock domain. */
module bcc_top_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic BUTTON_N,
  input wire logic FRAME_VALID,
  input wire logic FRAME_KNOWN,
  input wire logic CODE_HIT1,
  input wire logic CODE_HIT2,
  input wire logic MEM_FAULT,
  input wire logic WIPE_DONE,
  input wire logic OUT1,
  input wire logic OUT2,
  input wire logic LED_GREEN,
  input wire logic LED_RED,
  input wire logic LEARN_STB,
  input wire logic LEARN_CH2,
  input wire logic FORGET_STB,
  input wire logic WIPE_STB,
  input wire logic MEM_FULL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // LED fully dark
  sequence s_dark;
    !LED_GREEN && !LED_RED;
  endsequence
  // Quiet after reset; strobes trace back to a decoded frame; dark after a learn
  property p_quiet; !$past(RST_N) |-> !OUT1 && !OUT2 && !WIPE_STB ##0 s_dark; endproperty
  property p_learn; LEARN_STB |-> $past(FRAME_VALID); endproperty
  property p_forget; FORGET_STB |-> $past(FRAME_VALID) && $past(FRAME_KNOWN); endproperty
  property p_blank; LEARN_STB |=> s_dark [*8]; endproperty
  // Wipe: steady orange first, one strobe, dark after the reply
  property p_wipe_or; WIPE_STB |-> $past(LED_GREEN, 2) && $past(LED_RED, 2); endproperty
  property p_wipe_one; WIPE_STB |=> !WIPE_STB [*8]; endproperty
  property p_wipe_off; $rose(WIPE_DONE) |-> ##2 s_dark; endproperty
  // Fault flash keeps both colours in step
  property p_fault; $past(MEM_FAULT, 3) |-> LED_GREEN == LED_RED; endproperty
  a_quiet: assert property (p_quiet) else $error("outputs lit after reset");
  a_learn: assert property (p_learn) else $error("learn strobe without frame");
  a_forget: assert property (p_forget) else $error("forget without known frame");
  a_blank: assert property (p_blank) else $error("led lit after learn");
  a_wipe_or: assert property (p_wipe_or) else $error("wipe without orange");
  a_wipe_one: assert property (p_wipe_one) else $error("wipe strobe repeated");
  a_wipe_off: assert property (p_wipe_off) else $error("led lit after wipe");
  a_fault: assert property (p_fault) else $error("fault led not orange");
endmodule : bcc_top_monitor

bind bcc_top bcc_top_monitor bcc_top_monitor_i (.*);

// File: verif/bcc_mem_model.sv
/* Behavioural decoder and code memory facing bcc_top.
   Assumes the bench calls its tasks and shares the clock. */
module bcc_mem_model #(
  parameter int WIPE_DELAY = 20
) (
  input  wire logic clk,
  input  wire logic wipe_stb,
  output logic      frame_valid = 1'b0,
  output logic      frame_known = 1'b0,
  output logic      code_hit1   = 1'b0,
  output logic      code_hit2   = 1'b0,
  output logic      mem_fault   = 1'b0,
  output logic      wipe_done   = 1'b0
);
  int cnt_ff = 0;
  // Wipe is slow; reply is one pulse, never at once
  always @(posedge clk) begin
    wipe_done <= (cnt_ff == 1);
    cnt_ff <= wipe_stb ? WIPE_DELAY : (cnt_ff > 0 ? cnt_ff - 1 : 0);
  end
  // One decoded frame, v is known, hit1, hit2
  task automatic send(input logic [2:0] v);
    @(posedge clk);
    {frame_known, code_hit1, code_hit2} <= v;
    frame_valid <= 1'b1;
    @(posedge clk);
    {frame_valid, code_hit1, code_hit2} <= 3'h0;
  endtask : send
  // Fault level of the memory
  task automatic set_fault(input logic f);
    @(posedge clk);
    mem_fault <= f;
  endtask : set_fault
endmodule : bcc_mem_model

// File: verif/tb_bcc_top.sv
/* Self-checking bench for bcc_top, shortened timing: 1 ms is 1 cycle, a step 1 s.
   Assumes the params header is compiled first and the memory model beside. */
module tb_bcc_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic BUTTON_N = 1'b1;
  logic FRAME_VALID, FRAME_KNOWN, CODE_HIT1, CODE_HIT2, MEM_FAULT, WIPE_DONE;
  logic OUT1, OUT2, LED_GREEN, LED_RED, LEARN_STB, LEARN_CH2, FORGET_STB, WIPE_STB, MEM_FULL;
  int fails = 0;
  int n_compared = 0;
  // 200 MHz
  always #2.5 CLK = ~CLK;
  ////////////////////////////////////////////////////////////
  bcc_top #(.TICK_CYCLES(1), .STEP_MS(1000)) bcc_top_i (.*);
  bcc_mem_model bcc_mem_model_i (.clk(CLK), .wipe_stb(WIPE_STB), .frame_valid(FRAME_VALID),
    .frame_known(FRAME_KNOWN), .code_hit1(CODE_HIT1), .code_hit2(CODE_HIT2),
    .mem_fault(MEM_FAULT), .wipe_done(WIPE_DONE));
  ////////////////////////////////////////////////////////////
  // Helpers: time in 100-cycle units, compare, button, LED census, bounded wait
  task automatic ms(input int n);
    repeat (n * 100) @(posedge CLK);
  endtask : ms
  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic press(input int hold);
    @(posedge CLK) BUTTON_N <= 1'b0;
    ms(hold);
    BUTTON_N <= 1'b1;
    ms(4);
  endtask : press
  task automatic look(input int n, output int g, output int r);
    g = 0;
    r = 0;
    repeat (n * 10) begin
      repeat (10) @(posedge CLK);
      g += LED_GREEN;
      r += LED_RED;
    end
  endtask : look
  task automatic wait_for(ref logic sig, input string what);
    int i;
    for (i = 0; i < 2000 && sig !== 1'b1; i++)
      @(posedge CLK);
    chk(i < 2000, what);
    if (i >= 2000)
      close_out();
  endtask : wait_for
  ////////////////////////////////////////////////////////////
  // Scenarios, each judging its own outcome
  task automatic t_learn();
    int g, r;
    press(3);
    look(2, g, r);
    chk(g == 20 && r == 0, "learn one not green");
    bcc_mem_model_i.send(3'h0);
    wait_for(LEARN_STB, "no learn strobe");
    chk(LEARN_CH2 === 1'b0, "wrong learn channel");
    ms(60);
    look(2, g, r);
    chk(g + r == 0, "learn phase kept");
    press(3);
    press(3);
    look(2, g, r);
    chk(g == 0 && r == 20, "learn two not red");
    bcc_mem_model_i.send(3'h0);
    wait_for(LEARN_STB, "no learn strobe two");
    chk(LEARN_CH2 === 1'b1 && MEM_FULL === 1'b0, "learn two wrong");
    press(3);
    bcc_mem_model_i.send(3'h4);
    wait_for(FORGET_STB, "no forget strobe");
    ms(60);
    $display("learn test done");
  endtask : t_learn
  task automatic t_bist();
    int g, r;
    press(40);
    look(20, g, r);
    chk(g > 0 && g < 200 && r == 0, "no green fast flash");
    press(3);
    ms(80);
    bcc_mem_model_i.send(3'h6);
    ms(10);
    chk(OUT1 === 1'b1, "output one not latched");
    bcc_mem_model_i.send(3'h6);
    ms(2);
    chk(OUT1 === 1'b0, "output one not toggled");
    ms(10);
    $display("bistable test done");
  endtask : t_bist
  task automatic t_timed();
    int g, r;
    press(40);
    repeat (2) press(3);
    ms(50);
    look(2, g, r);
    chk(g == 20 && r == 20, "no orange entry");
    @(posedge CLK) BUTTON_N <= 1'b0;
    ms(3);
    look(1, g, r);
    chk(g == 10 && r == 0, "no press echo");
    BUTTON_N <= 1'b1;
    ms(4);
    press(3);
    ms(60);
    bcc_mem_model_i.send(3'h6);
    ms(15);
    chk(OUT1 & LED_GREEN & ~LED_RED, "timed output short");
    ms(10);
    chk(OUT1 === 1'b0, "timed output long");
    $display("timed test done");
  endtask : t_timed
  task automatic t_abort();
    int g, r;
    press(3);
    press(40);
    look(10, g, r);
    chk(r > 0 && r < 100 && g == 0, "no red fast flash");
    repeat (3) press(3);
    look(5, g, r);
    chk(g + r == 0, "abort not quiet");
    bcc_mem_model_i.send(3'h6);
    ms(15);
    chk(OUT1 === 1'b1, "channel one mode lost");
    ms(15);
    $display("abort test done");
  endtask : t_abort
  task automatic t_wipe();
    int g, r;
    repeat (2) press(3);
    @(posedge CLK) BUTTON_N <= 1'b0;
    ms(36);
    look(2, g, r);
    chk(g == 20 && r == 20, "no steady orange");
    BUTTON_N <= 1'b1;
    wait_for(WIPE_STB, "no wipe strobe");
    wait_for(WIPE_DONE, "no wipe reply");
    ms(1);
    look(2, g, r);
    chk(g + r == 0, "led lit after wipe");
    bcc_mem_model_i.send(3'h7);
    ms(1);
    chk(OUT1 & OUT2 & LED_GREEN & LED_RED, "no orange for both");
    ms(10);
    chk(OUT1 === 1'b0 && OUT2 === 1'b0, "not monostable");
    $display("wipe test done");
  endtask : t_wipe
  task automatic t_fault();
    int g, r;
    bcc_mem_model_i.set_fault(1'b1);
    ms(1);
    look(20, g, r);
    chk(g === r && g > 0 && g < 200, "no orange flashing");
    bcc_mem_model_i.set_fault(1'b0);
    RST_N <= 1'b0;
    ms(1);
    RST_N <= 1'b1;
    ms(1);
    chk(LED_GREEN === 1'b0 && OUT1 === 1'b0, "fault kept after reset");
    $display("fault test done");
  endtask : t_fault
  // Counts, verdict and end of run
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    ms(1);
    t_learn();
    t_bist();
    t_timed();
    t_abort();
    t_wipe();
    t_fault();
    close_out();
  end
endmodule : tb_bcc_top
